// file: rtl/tcbl_top.sv
// compare registers of channels 2 to 4, break and output protection
//
// How it works
// - write reaches active compare now or at update
// - active compare matched against counter drives output
// - input mode captures counter; channel 2 read-only
// - compare split into high and low bytes
// - enabled break clears main enable immediately
// - main enable set by software or auto
// - main enable off idles outputs, on uses enables
// - auto enable sets main at update without break
// - break polarity picks active level
// - break enable gates the break input
// - run off-state drives inactive level when enabled
// - idle off-state drives idle level when enabled
// - lock 01 protects idle levels and break config
// - lock 10 adds polarity and off-state bits
// - lock 11 adds mode and preload bits
// - lock field written once after reset
// - main enable off leaves outputs undriven unless idle off-state set
`timescale 1ns/1ns
module tcbl_top #(
  parameter int CNT_W = 16
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [tcbl_pkg::ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [tcbl_pkg::ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [CNT_W-1:0] I_COUNTER_VALUE,
  input wire logic I_UPDATE_EVENT,
  input wire logic [tcbl_pkg::NCH-1:0] I_CAPTURE_EVENT,
  input wire logic I_BREAK_INPUT,
  output logic [tcbl_pkg::NCH-1:0] O_COMPARE_OUT,
  output logic [tcbl_pkg::NCH-1:0] O_OC_LEVEL,
  output logic [tcbl_pkg::NCH-1:0] O_OC_DRIVE,
  output logic [1:0] O_OCN_LEVEL,
  output logic [1:0] O_OCN_DRIVE,
  output logic O_IRQ
);

  typedef struct packed {
    logic aw_full;
    logic [5:0] aw_idx;
    logic w_full;
    logic [7:0] w_byte;
    logic w_en;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic lock_done;
    tcbl_pkg::tcbl_bkr_t bkr;
    tcbl_pkg::tcbl_idle_t idle;
    tcbl_pkg::tcbl_chcfg_t [tcbl_pkg::NCH-1:0] cfg;
    logic [tcbl_pkg::NCH-1:0][CNT_W-1:0] preload;
    logic [tcbl_pkg::NCH-1:0][CNT_W-1:0] active;
    logic [tcbl_pkg::NCH-1:0] ref_lvl;
    logic [tcbl_pkg::NCH-1:0] oc_lvl;
    logic [tcbl_pkg::NCH-1:0] oc_drv;
    logic [1:0] ocn_lvl;
    logic [1:0] ocn_drv;
    logic [tcbl_pkg::IRQ_W-1:0] istat;
    logic [tcbl_pkg::IRQ_W-1:0] imask;
    logic irq;
  } tcbl_state_t;

  tcbl_state_t s_q;
  tcbl_state_t s_d;
  logic brk_act;
  logic moe_eff;

  // register index from byte address
  function automatic logic [5:0] reg_index(input logic [tcbl_pkg::ADDR_W-1:0] a);
    reg_index = a[tcbl_pkg::IDX_LSB +: 6];
  endfunction : reg_index

  function automatic logic idx_mapped(input logic [5:0] i);
    idx_mapped = (i >= tcbl_pkg::IDX_CV2H && i <= tcbl_pkg::IDX_BKR) ||
      (i >= tcbl_pkg::IDX_IDLE && i <= tcbl_pkg::IDX_IMASK);
  endfunction : idx_mapped

  // keep old bits where protect mask is set
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] prot);
    merge = (old_v & prot) | (new_v & ~prot);
  endfunction : merge

  assign brk_act = s_q.bkr.break_enable & (I_BREAK_INPUT == s_q.bkr.break_polarity);
  assign moe_eff = s_q.bkr.main_output_enable & ~brk_act;

  always_comb begin
    logic wr_fire;
    logic [5:0] wi;
    logic [5:0] ri;
    logic [7:0] prot;
    logic [7:0] rb;
    logic match;
    logic inact;
    logic lvl;
    logic [CNT_W-1:0] pre_n;
    logic [tcbl_pkg::IRQ_W-1:0] ev;
    tcbl_pkg::tcbl_chcfg_t c;
    wr_fire = 1'b0;
    wi = '0;
    ri = '0;
    prot = '0;
    rb = '0;
    match = 1'b0;
    inact = 1'b0;
    lvl = 1'b0;
    pre_n = '0;
    ev = '0;
    c = '0;
    s_d = s_q;

    // bus handshakes
    if (I_AWVALID && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_idx = reg_index(I_AWADDR);
    end
    if (I_WVALID && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.w_byte = I_WDATA[7:0];
      s_d.w_en = I_WSTRB[0];
    end
    if (s_q.bvalid && I_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    wr_fire = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    wi = s_q.aw_idx;
    if (wr_fire) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = idx_mapped(wi) ? tcbl_pkg::RESP_OKAY : tcbl_pkg::RESP_SLVERR;
    end

    // break register write, lock-aware
    if (wr_fire && s_q.w_en && wi == tcbl_pkg::IDX_BKR) begin
      prot = '0;
      if (s_q.bkr.lock != tcbl_pkg::LOCK_OFF) begin
        prot[6:4] = 3'h7;
      end
      if (s_q.bkr.lock == tcbl_pkg::LOCK_L2 || s_q.bkr.lock == tcbl_pkg::LOCK_L3) begin
        prot[3:2] = 2'h3;
      end
      if (s_q.lock_done) begin
        prot[1:0] = 2'h3;
      end
      s_d.bkr = merge(s_q.bkr, s_q.w_byte, prot);
      s_d.lock_done = 1'b1;
    end
    if (wr_fire && s_q.w_en && wi == tcbl_pkg::IDX_IDLE && s_q.bkr.lock == tcbl_pkg::LOCK_OFF) begin
      s_d.idle = s_q.w_byte[5:0];
    end
    if (wr_fire && s_q.w_en && wi == tcbl_pkg::IDX_IMASK) begin
      s_d.imask = s_q.w_byte[tcbl_pkg::IRQ_W-1:0];
    end

    // main output enable: auto set, then break clear wins
    if (s_q.bkr.auto_output_enable && I_UPDATE_EVENT && !brk_act) begin
      s_d.bkr.main_output_enable = 1'b1;
    end
    if (brk_act) begin
      s_d.bkr.main_output_enable = 1'b0;
      ev[tcbl_pkg::IRQ_BREAK] = 1'b1;
    end

    for (int i = 0; i < tcbl_pkg::NCH; i++) begin
      c = s_q.cfg[i];
      // channel config with lock on output channels
      if (wr_fire && s_q.w_en && wi == tcbl_pkg::IDX_CFG2 + 6'(i)) begin
        prot = '0;
        if (!c.direction_input && (s_q.bkr.lock == tcbl_pkg::LOCK_L2 || s_q.bkr.lock == tcbl_pkg::LOCK_L3)) begin
          prot[5] = 1'b1;
        end
        if (!c.direction_input && s_q.bkr.lock == tcbl_pkg::LOCK_L3) begin
          prot[4:1] = 4'hf;
        end
        s_d.cfg[i] = merge(s_q.cfg[i], s_q.w_byte, prot);
      end
      // preload bytes, channel 2 read-only while capturing
      pre_n = s_q.preload[i];
      if (wr_fire && s_q.w_en && !(i == 0 && c.direction_input)) begin
        if (wi == tcbl_pkg::IDX_CV2H + 6'(2 * i)) begin
          pre_n[15:8] = s_q.w_byte;
        end
        if (wi == tcbl_pkg::IDX_CV2L + 6'(2 * i)) begin
          pre_n[7:0] = s_q.w_byte;
        end
      end
      if (c.direction_input && I_CAPTURE_EVENT[i]) begin
        pre_n = I_COUNTER_VALUE;
        ev[i] = 1'b1;
      end
      s_d.preload[i] = pre_n;
      if (!c.preload_enable || (I_UPDATE_EVENT && !c.direction_input)) begin
        s_d.active[i] = pre_n;
      end

      // reference waveform from the compare mode
      match = !c.direction_input && (I_COUNTER_VALUE == s_q.active[i]);
      if (match) begin
        ev[tcbl_pkg::IRQ_MATCH + i] = 1'b1;
      end
      case (c.output_compare_mode)
        tcbl_pkg::OCM_SET: s_d.ref_lvl[i] = match ? 1'b1 : s_q.ref_lvl[i];
        tcbl_pkg::OCM_CLEAR: s_d.ref_lvl[i] = match ? 1'b0 : s_q.ref_lvl[i];
        tcbl_pkg::OCM_TOGGLE: s_d.ref_lvl[i] = match ^ s_q.ref_lvl[i];
        tcbl_pkg::OCM_FORCE_LOW: s_d.ref_lvl[i] = 1'b0;
        tcbl_pkg::OCM_FORCE_HIGH: s_d.ref_lvl[i] = 1'b1;
        tcbl_pkg::OCM_PWM1: s_d.ref_lvl[i] = I_COUNTER_VALUE < s_q.active[i];
        tcbl_pkg::OCM_PWM2: s_d.ref_lvl[i] = !(I_COUNTER_VALUE < s_q.active[i]);
        default: s_d.ref_lvl[i] = s_q.ref_lvl[i];
      endcase

      // pin stage for the direct output
      lvl = s_q.ref_lvl[i] ^ c.channel_polarity;
      inact = c.channel_polarity;
      s_d.oc_lvl[i] = 1'b0;
      s_d.oc_drv[i] = 1'b0;
      if (c.direction_input) begin
        s_d.oc_drv[i] = 1'b0;
      end else if (moe_eff) begin
        if (c.channel_output_enable) begin
          s_d.oc_lvl[i] = lvl;
          s_d.oc_drv[i] = 1'b1;
        end else if (i < 2 && s_q.bkr.run_off_state_select && c.complementary_output_enable) begin
          s_d.oc_lvl[i] = inact;
          s_d.oc_drv[i] = 1'b1;
        end
      end else if (s_q.bkr.idle_off_state_select && c.channel_output_enable) begin
        s_d.oc_lvl[i] = s_q.idle[2 * i];
        s_d.oc_drv[i] = 1'b1;
      end

      // complementary output, channels 2 and 3 only
      if (i < 2) begin
        s_d.ocn_lvl[i] = 1'b0;
        s_d.ocn_drv[i] = 1'b0;
        if (!c.direction_input && moe_eff) begin
          if (c.complementary_output_enable) begin
            s_d.ocn_lvl[i] = !lvl;
            s_d.ocn_drv[i] = 1'b1;
          end else if (s_q.bkr.run_off_state_select && c.channel_output_enable) begin
            s_d.ocn_lvl[i] = !inact;
            s_d.ocn_drv[i] = 1'b1;
          end
        end else if (!c.direction_input && s_q.bkr.idle_off_state_select && c.complementary_output_enable) begin
          s_d.ocn_lvl[i] = s_q.idle[2 * i + 1];
          s_d.ocn_drv[i] = 1'b1;
        end
      end
    end

    // sticky status, set wins over write-one clear
    if (wr_fire && s_q.w_en && wi == tcbl_pkg::IDX_ISTAT) begin
      s_d.istat = s_q.istat & ~s_q.w_byte[tcbl_pkg::IRQ_W-1:0];
    end
    s_d.istat = s_d.istat | ev;
    s_d.irq = |(s_d.istat & s_d.imask);

    // read channel
    if (s_q.rvalid && I_RREADY) begin
      s_d.rvalid = 1'b0;
    end
    if (I_ARVALID && s_q.arready) begin
      ri = reg_index(I_ARADDR);
      case (ri)
        tcbl_pkg::IDX_CV2H: rb = s_q.preload[0][15:8];
        tcbl_pkg::IDX_CV2L: rb = s_q.preload[0][7:0];
        tcbl_pkg::IDX_CV3H: rb = s_q.preload[1][15:8];
        tcbl_pkg::IDX_CV3L: rb = s_q.preload[1][7:0];
        tcbl_pkg::IDX_CV4H: rb = s_q.preload[2][15:8];
        tcbl_pkg::IDX_CV4L: rb = s_q.preload[2][7:0];
        tcbl_pkg::IDX_BKR: rb = {moe_eff, s_q.bkr[6:0]};
        tcbl_pkg::IDX_IDLE: rb = {2'h0, s_q.idle};
        tcbl_pkg::IDX_CFG2: rb = s_q.cfg[0];
        tcbl_pkg::IDX_CFG3: rb = s_q.cfg[1];
        tcbl_pkg::IDX_CFG4: rb = s_q.cfg[2];
        tcbl_pkg::IDX_ISTAT: rb = {1'b0, s_q.istat};
        tcbl_pkg::IDX_IMASK: rb = {1'b0, s_q.imask};
        default: rb = '0;
      endcase
      s_d.rdata = rb;
      s_d.rresp = idx_mapped(ri) ? tcbl_pkg::RESP_OKAY : tcbl_pkg::RESP_SLVERR;
      s_d.rvalid = 1'b1;
    end
    s_d.arready = !s_d.rvalid;
    s_d.awready = !s_d.aw_full && !s_d.bvalid;
    s_d.wready = !s_d.w_full && !s_d.bvalid;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      s_q <= '0;
      s_q.bkr <= tcbl_pkg::RST_BYTE;
      s_q.preload <= {tcbl_pkg::NCH{tcbl_pkg::RST_WORD}};
      s_q.active <= {tcbl_pkg::NCH{tcbl_pkg::RST_WORD}};
    end else begin
      s_q <= s_d;
    end
  end

  assign O_AWREADY = s_q.awready;
  assign O_WREADY = s_q.wready;
  assign O_BVALID = s_q.bvalid;
  assign O_BRESP = s_q.bresp;
  assign O_ARREADY = s_q.arready;
  assign O_RVALID = s_q.rvalid;
  assign O_RRESP = s_q.rresp;
  assign O_RDATA = {24'h000000, s_q.rdata};
  assign O_COMPARE_OUT = s_q.ref_lvl;
  assign O_OC_LEVEL = s_q.oc_lvl;
  assign O_OC_DRIVE = s_q.oc_drv;
  assign O_OCN_LEVEL = s_q.ocn_lvl;
  assign O_OCN_DRIVE = s_q.ocn_drv;
  assign O_IRQ = s_q.irq;

endmodule : tcbl_top

// file: rtl/tcbl_pkg.sv
// shared constants and types for the timer compare and break block
package tcbl_pkg;
  localparam int ADDR_W = 8;
  localparam int NCH = 3;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CV2H = 6'h18;
  localparam logic [5:0] IDX_CV2L = 6'h19;
  localparam logic [5:0] IDX_CV3H = 6'h1a;
  localparam logic [5:0] IDX_CV3L = 6'h1b;
  localparam logic [5:0] IDX_CV4H = 6'h1c;
  localparam logic [5:0] IDX_CV4L = 6'h1d;
  localparam logic [5:0] IDX_BKR = 6'h1e;
  localparam logic [5:0] IDX_IDLE = 6'h30;
  localparam logic [5:0] IDX_CFG2 = 6'h31;
  localparam logic [5:0] IDX_CFG3 = 6'h32;
  localparam logic [5:0] IDX_CFG4 = 6'h33;
  localparam logic [5:0] IDX_ISTAT = 6'h34;
  localparam logic [5:0] IDX_IMASK = 6'h35;
  localparam int IDX_LSB = 2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] LOCK_OFF = 2'h0;
  localparam logic [1:0] LOCK_L1 = 2'h1;
  localparam logic [1:0] LOCK_L2 = 2'h2;
  localparam logic [1:0] LOCK_L3 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status bits: [2:0] capture ch2..4, [5:3] match ch2..4, [6] break
  localparam int IRQ_W = 7;
  localparam int IRQ_MATCH = 3;
  localparam int IRQ_BREAK = 6;
  typedef enum logic [2:0] {
    OCM_FROZEN = 3'h0, OCM_SET = 3'h1, OCM_CLEAR = 3'h2, OCM_TOGGLE = 3'h3,
    OCM_FORCE_LOW = 3'h4, OCM_FORCE_HIGH = 3'h5, OCM_PWM1 = 3'h6, OCM_PWM2 = 3'h7
  } tcbl_ocm_t;
  // per-channel configuration byte, dir=1 means input capture
  typedef struct packed {
    logic complementary_output_enable;
    logic channel_output_enable;
    logic channel_polarity;
    tcbl_ocm_t output_compare_mode;
    logic preload_enable;
    logic direction_input;
  } tcbl_chcfg_t;
  typedef struct packed {
    logic main_output_enable;
    logic auto_output_enable;
    logic break_polarity;
    logic break_enable;
    logic run_off_state_select;
    logic idle_off_state_select;
    logic [1:0] lock;
  } tcbl_bkr_t;
  // idle levels: bit 2i direct, bit 2i+1 complementary
  typedef logic [5:0] tcbl_idle_t;
endpackage : tcbl_pkg

// file: testbench/tcbl_break_src.sv
// break source and power stage beside the compare and break block
`timescale 1ns/1ns
module tcbl_break_src (
  input wire logic i_fault,
  input wire logic i_active_high,
  input wire logic [2:0] i_oc_drive,
  input wire logic [2:0] i_oc_level,
  output logic o_break,
  output logic [2:0] o_pad
);
  assign o_break = i_active_high ? i_fault : !i_fault;
  // undriven pads fall to the pull-down
  assign o_pad = i_oc_drive & i_oc_level;
endmodule : tcbl_break_src

// file: testbench/tcbl_top_assertions.sv
// port assertions for the compare and break block
`timescale 1ns/1ns
module tcbl_top_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [tcbl_pkg::NCH-1:0] O_OC_DRIVE,
  input wire logic [tcbl_pkg::NCH-1:0] O_COMPARE_OUT,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_RST);
  a_reset_quiet: assert property ($past(I_RST) |-> !O_IRQ && O_OC_DRIVE == '0 && O_COMPARE_OUT == '0)
    else $error("outputs active after reset");
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:3] O_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read data missing");
  a_write_busy: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write accepted while response pending");
  a_read_busy: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read accepted while data pending");
  a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  a_rdata_byte: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
    else $error("read data above byte");
  c_slverr: cover property (O_BVALID && O_BRESP == tcbl_pkg::RESP_SLVERR);
  c_irq: cover property ($rose(O_IRQ));
  c_cmp: cover property ($fell(O_COMPARE_OUT[0]));
endmodule : tcbl_top_chk
bind tcbl_top tcbl_top_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_AWVALID(I_AWVALID),
  .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY), .O_OC_DRIVE(O_OC_DRIVE), .O_COMPARE_OUT(O_COMPARE_OUT), .O_IRQ(O_IRQ));

// file: testbench/tb.sv
// self-checking bench for the compare and break block
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, upd = 1'b0, fault = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, rbyte;
  logic [31:0] wd = 32'h0, rdata;
  logic [15:0] cnt = 16'h0;
  logic [2:0] cap = 3'h0, cmp, ocl, ocd, pad;
  logic [1:0] resp, bresp, rresp, ocnl, ocnd;
  logic awr, wrd, bv, arr, rv, irq, brk;
  int n_mismatch = 0, total_checks = 0;
  always #50 clk = ~clk;
  tcbl_top uut (.I_CORE_CLK(clk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_WDATA(wd), .I_WSTRB(4'h1), .I_WVALID(wv), .O_WREADY(wrd), .O_BRESP(bresp), .O_BVALID(bv),
    .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rv), .I_RREADY(rry), .I_COUNTER_VALUE(cnt), .I_UPDATE_EVENT(upd), .I_CAPTURE_EVENT(cap),
    .I_BREAK_INPUT(brk), .O_COMPARE_OUT(cmp), .O_OC_LEVEL(ocl), .O_OC_DRIVE(ocd), .O_OCN_LEVEL(ocnl),
    .O_OCN_DRIVE(ocnd), .O_IRQ(irq));
  tcbl_break_src u_src (.i_fault(fault), .i_active_high(1'b1), .i_oc_drive(ocd), .i_oc_level(ocl),
    .o_break(brk), .o_pad(pad));
  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    tick(8);
    rst <= 1'b0;
  endtask : do_reset
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic a_ok, w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    awa <= {idx, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk);
      if (awr && !a_ok) begin
        a_ok = 1'b1;
        awv <= 1'b0;
      end
      if (wrd && !w_ok) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    tick(2);
    bry <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    resp = bresp;
    bry <= 1'b0;
  endtask : wr
  task automatic rc(input logic [5:0] idx, input logic [7:0] e, input string nm);
    @(posedge clk);
    ara <= {idx, 2'h0};
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    @(posedge clk);
    rry <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    rbyte = rdata[7:0];
    resp = rresp;
    rry <= 1'b0;
    chk(nm, e, rbyte);
  endtask : rc
  task automatic pulse(input logic u, input logic [2:0] c);
    @(posedge clk);
    upd <= u;
    cap <= c;
    @(posedge clk);
    upd <= 1'b0;
    cap <= 3'h0;
  endtask : pulse
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rc(tcbl_pkg::IDX_CV2H + 6'(i), tcbl_pkg::RST_BYTE, "reset");
    end
  endtask : t_reset
  task automatic t_compare();
    wr(tcbl_pkg::IDX_CFG2, 8'h18);
    wr(tcbl_pkg::IDX_CV2H, 8'h12);
    wr(tcbl_pkg::IDX_CV2L, 8'h34);
    rc(tcbl_pkg::IDX_CV2H, 8'h12, "cv2h");
    rc(tcbl_pkg::IDX_CV2L, 8'h34, "cv2l");
    cnt <= 16'h1233;
    tick(3);
    chk("cmp", 8'h01, {7'h0, cmp[0]});
    cnt <= 16'h1234;
    tick(3);
    chk("cmp", 8'h00, {7'h0, cmp[0]});
    wr(tcbl_pkg::IDX_CFG2, 8'h1a);
    wr(tcbl_pkg::IDX_CV2L, 8'h00);
    cnt <= 16'h1200;
    tick(3);
    chk("cmp", 8'h01, {7'h0, cmp[0]});
    pulse(1'b1, 3'h0);
    tick(3);
    chk("cmp", 8'h00, {7'h0, cmp[0]});
  endtask : t_compare
  task automatic t_capture();
    wr(tcbl_pkg::IDX_CFG3, 8'h01);
    cnt <= 16'habcd;
    pulse(1'b0, 3'h2);
    rc(tcbl_pkg::IDX_CV3H, 8'hab, "cv3h");
    rc(tcbl_pkg::IDX_CV3L, 8'hcd, "cv3l");
    wr(tcbl_pkg::IDX_CFG2, 8'h01);
    cnt <= 16'h5566;
    pulse(1'b0, 3'h1);
    wr(tcbl_pkg::IDX_CV2H, 8'hff);
    rc(tcbl_pkg::IDX_CV2H, 8'h55, "cv2h");
  endtask : t_capture
  task automatic t_irq();
    wr(tcbl_pkg::IDX_IMASK, 8'h02);
    tick(2);
    chk("irq", 8'h01, {7'h0, irq});
    wr(tcbl_pkg::IDX_IMASK, 8'h00);
    tick(2);
    chk("irq", 8'h00, {7'h0, irq});
    wr(tcbl_pkg::IDX_IMASK, 8'h02);
    wr(tcbl_pkg::IDX_ISTAT, 8'h02);
    tick(2);
    chk("irq", 8'h00, {7'h0, irq});
    wr(6'h3f, 8'h5a);
    chk("resp", {6'h0, tcbl_pkg::RESP_SLVERR}, {6'h0, resp});
    rc(6'h3f, 8'h00, "unmapped");
    chk("rresp", {6'h0, tcbl_pkg::RESP_SLVERR}, {6'h0, resp});
  endtask : t_irq
  task automatic t_break();
    wr(tcbl_pkg::IDX_IDLE, 8'h03);
    wr(tcbl_pkg::IDX_CFG2, 8'hc0);
    tick(3);
    chk("pad", 8'h00, {7'h0, pad[0]});
    chk("ocn drive", 8'h00, {7'h0, ocnd[0]});
    wr(tcbl_pkg::IDX_BKR, 8'hf5);
    rc(tcbl_pkg::IDX_BKR, 8'hf5, "bkr");
    fault <= 1'b1;
    tick(3);
    rc(tcbl_pkg::IDX_BKR, 8'h75, "bkr");
    chk("pad", 8'h01, {7'h0, pad[0]});
    chk("ocn drive", 8'h01, {7'h0, ocnd[0]});
    chk("ocn level", 8'h01, {7'h0, ocnl[0]});
    fault <= 1'b0;
    rc(tcbl_pkg::IDX_BKR, 8'h75, "bkr");
    pulse(1'b1, 3'h0);
    rc(tcbl_pkg::IDX_BKR, 8'hf5, "bkr");
    chk("oc drive", 8'h01, {5'h0, ocd});
    wr(tcbl_pkg::IDX_BKR, 8'h8e);
    rc(tcbl_pkg::IDX_BKR, 8'hfd, "bkr");
    wr(tcbl_pkg::IDX_CFG2, 8'h40);
    tick(3);
    chk("ocn drive", 8'h01, {7'h0, ocnd[0]});
    wr(tcbl_pkg::IDX_IDLE, 8'h3f);
    rc(tcbl_pkg::IDX_IDLE, 8'h03, "idle");
  endtask : t_break
  task automatic t_lock3();
    do_reset();
    wr(tcbl_pkg::IDX_BKR, 8'h83);
    rc(tcbl_pkg::IDX_BKR, 8'h83, "bkr");
    wr(tcbl_pkg::IDX_CFG4, 8'h7e);
    rc(tcbl_pkg::IDX_CFG4, 8'h40, "cfg4");
    wr(tcbl_pkg::IDX_BKR, 8'h0c);
    rc(tcbl_pkg::IDX_BKR, 8'h03, "bkr");
  endtask : t_lock3
  initial begin
    do_reset();
    t_reset();
    t_compare();
    t_capture();
    t_irq();
    t_break();
    t_lock3();
    give_verdict();
  end
  initial begin
    tick(5000);
    n_mismatch++;
    give_verdict();
  end
endmodule : tb
